/* logic/mpws_params.svh */
// Timing constants and counter width of the power and wake sequencer
`ifndef MPWS_PARAMS_SVH
`define MPWS_PARAMS_SVH
`define MPWS_CLK_HZ        25000000
`define MPWS_ON_MIN_MS     500
`define MPWS_ON_MAX_MS     1000
`define MPWS_OFF_MIN_MS    650
`define MPWS_OFF_MAX_MS    1500
`define MPWS_WAKE_LOW_MS   200
`define MPWS_RESET_MIN_MS  100
`define MPWS_CYC_PER_MS    (`MPWS_CLK_HZ / 1000)
`define MPWS_MS_CYCLES(ms, cpm) ((ms) * (cpm))
`define MPWS_CNT_W         26
`endif

/* logic/mpws_pkg.sv */
// Types shared by the power and wake sequencer
package mpws_pkg;
   typedef enum logic [2:0]
   {
      MPWS_OFF,
      MPWS_BOOT,
      MPWS_RUN,
      MPWS_PSAVE,
      MPWS_SHUTDOWN
   } mpws_state_t;
endpackage

/* logic/mpws_pulse_meter.sv */
// Low-pulse width meter for an active-low input line
`timescale 1ns/100ps
module mpws_pulse_meter
#(
   parameter int CNT_W = 26
)
(
   input  wire logic             ref_clk,   // System clock
   input  wire logic             reset,     // Async reset, active high
   input  wire logic             line_n,    // Active-low line
   output logic                  released,  // Pulse on low-to-high edge
   output logic [CNT_W-1:0]      width      // Low time in cycles
);
   // -----------------------------------------------------------------
   // Width counter
   // -----------------------------------------------------------------
   logic             prev;   // Previous line level
   logic [CNT_W-1:0] count;  // Running low count

   // Count cycles while low, saturating
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         count <= '0;
      else if (line_n)
         count <= '0;
      else if (~&count)
         count <= count + 1'b1;
   end

   // Edge detect and latch width at release
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         prev     <= 1'b1;
         released <= 1'b0;
         width    <= '0;
      end
      else
      begin
         prev     <= line_n;
         released <= line_n & ~prev;
         if (line_n & ~prev)
            width <= count;
      end
   end
endmodule

/* logic/mpws_sequencer.sv */
// Power, reset and wake sequencer of the cellular module
`timescale 1ns/100ps
`include "mpws_params.svh"
module mpws_sequencer
   import mpws_pkg::*;
#(
   parameter int CNT_W      = `MPWS_CNT_W,       // Counter width
   parameter int CYC_PER_MS = `MPWS_CYC_PER_MS   // Clock cycles per ms
)
(
   input  wire logic ref_clk,              // 25 MHz clock
   input  wire logic reset,                // Async reset, active high
   input  wire logic power_key_n,          // Power key, active low
   input  wire logic reset_n,              // Module reset line, low
   input  wire logic wake_trigger,         // Wake line, pulled low
   input  wire logic power_down_command,   // Power-down command pulse
   input  wire logic power_saving_enable_command, // Enable level
   input  wire logic periodic_update_timer,       // Timer expiry pulse
   output logic      powered,              // Module running
   output logic      uart_enable,          // Main UART accessible
   output logic      registered_deep_sleep,// In deep sleep
   output logic      module_reset          // Internal reset pulse
);
   // -----------------------------------------------------------------
   // Timing counts
   // -----------------------------------------------------------------
   localparam logic [CNT_W-1:0] ON_MIN =
      CNT_W'(`MPWS_MS_CYCLES(`MPWS_ON_MIN_MS, CYC_PER_MS));
   localparam logic [CNT_W-1:0] ON_MAX =
      CNT_W'(`MPWS_MS_CYCLES(`MPWS_ON_MAX_MS, CYC_PER_MS));
   localparam logic [CNT_W-1:0] OFF_MIN =
      CNT_W'(`MPWS_MS_CYCLES(`MPWS_OFF_MIN_MS, CYC_PER_MS));
   localparam logic [CNT_W-1:0] OFF_MAX =
      CNT_W'(`MPWS_MS_CYCLES(`MPWS_OFF_MAX_MS, CYC_PER_MS));
   localparam logic [CNT_W-1:0] WAKE_WIN =
      CNT_W'(`MPWS_MS_CYCLES(`MPWS_WAKE_LOW_MS, CYC_PER_MS));
   localparam logic [CNT_W-1:0] RST_MIN =
      CNT_W'(`MPWS_MS_CYCLES(`MPWS_RESET_MIN_MS, CYC_PER_MS));

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   mpws_state_t      state;        // Sequencer state
   logic             key_rel;      // Power key released
   logic [CNT_W-1:0] key_w;        // Key low width
   logic             rst_rel;      // Reset line released
   logic [CNT_W-1:0] rst_w;        // Reset low width
   logic [CNT_W-1:0] win;          // Wake-low window timer
   logic             woke_by_host; // Wake trigger seen high since wake
   logic             wake;         // Resolved wake level
   logic             cmd_off;      // Last power-down was by command

   // Undriven line is already resolved low by the board pull-down
   assign wake = wake_trigger;

   // Is a width within inclusive window
   function automatic logic in_win(input logic [CNT_W-1:0] w,
                                   input logic [CNT_W-1:0] lo,
                                   input logic [CNT_W-1:0] hi);
      in_win = (w >= lo) && (w <= hi);
   endfunction

   // -----------------------------------------------------------------
   // Pulse meters
   // -----------------------------------------------------------------
   mpws_pulse_meter #(.CNT_W(CNT_W)) u_key
   (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .line_n   (power_key_n),
      .released (key_rel),
      .width    (key_w)
   );

   mpws_pulse_meter #(.CNT_W(CNT_W)) u_rst
   (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .line_n   (reset_n),
      .released (rst_rel),
      .width    (rst_w)
   );

   // -----------------------------------------------------------------
   // Main state machine
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state   <= MPWS_OFF;
         win     <= '0;
         cmd_off <= 1'b0;
      end
      else
      begin
         case (state)
            // Powered off, waiting for a valid on-pulse
            MPWS_OFF:
               if (key_rel && in_win(key_w, ON_MIN, ON_MAX))
                  state <= MPWS_RUN;
            // Unused transient state, go back to off
            MPWS_BOOT:
               state <= MPWS_OFF;
            // Running normally
            MPWS_RUN:
            begin
               if (key_rel && in_win(key_w, OFF_MIN, OFF_MAX))
               begin
                  state   <= MPWS_SHUTDOWN;
                  win     <= '0;
                  cmd_off <= 1'b0;
               end
               else if (power_down_command)
               begin
                  state   <= MPWS_SHUTDOWN;
                  win     <= '0;
                  cmd_off <= 1'b1;
               end
               else if (power_saving_enable_command && !wake)
                  state <= MPWS_PSAVE;
            end
            // Deep sleep; host wake or timer expiry leaves it
            MPWS_PSAVE:
               if (wake || periodic_update_timer)
                  state <= MPWS_RUN;
            // Waiting for wake low inside its window
            MPWS_SHUTDOWN:
            begin
               if (!wake)
                  state <= MPWS_OFF;
               else if (win >= WAKE_WIN)
                  state <= MPWS_RUN;  // Window missed, back to run
               else
                  win <= win + 1'b1;
            end
            default:
               state <= MPWS_OFF;
         endcase
      end
   end

   // Track whether host raised wake since the last deep-sleep exit
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         woke_by_host <= 1'b0;
      else if (state == MPWS_OFF)
         woke_by_host <= wake;
      else if (state == MPWS_PSAVE)
         woke_by_host <= 1'b0;
      else if (wake)
         woke_by_host <= 1'b1;
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         powered               <= 1'b0;
         uart_enable           <= 1'b0;
         registered_deep_sleep <= 1'b0;
      end
      else
      begin
         powered               <= (state == MPWS_RUN);
         registered_deep_sleep <= (state == MPWS_PSAVE);
         uart_enable <= (state == MPWS_RUN) && wake
                        && woke_by_host;
      end
   end

   // Reset pulse after a long enough reset-line low
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         module_reset <= 1'b0;
      else
         module_reset <= rst_rel && (rst_w >= RST_MIN);
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence s_on_pulse;
      state == MPWS_OFF && key_rel && in_win(key_w, ON_MIN, ON_MAX);
   endsequence

   a_power_on_pulse: assert property (s_on_pulse |=> ##1 powered)
      else $error("power-on pulse did not start module");
   a_short_on_ignored: assert property (
      state == MPWS_OFF && key_rel && key_w < ON_MIN |=> state == MPWS_OFF)
      else $error("short pulse started module");
   a_uart_wake_high: assert property (uart_enable |-> $past(wake))
      else $error("uart open with wake low");
   a_psave_entry: assert property (
      state == MPWS_RUN && !key_rel && !power_down_command
      && power_saving_enable_command && !wake
      |=> ##1 registered_deep_sleep)
      else $error("deep sleep not entered");
   a_psave_exit: assert property (
      state == MPWS_PSAVE && wake |=> ##1 powered)
      else $error("deep sleep not left");
   a_timer_uart_closed: assert property (
      state == MPWS_PSAVE && !wake && periodic_update_timer
      |=> ##1 !uart_enable)
      else $error("uart open after timer wake");
   a_shutdown_done: assert property (
      state == MPWS_SHUTDOWN && !wake |=> state == MPWS_OFF ##1 !powered)
      else $error("shutdown not completed");
   a_reset_min: assert property (
      module_reset |-> $past(rst_w) >= RST_MIN)
      else $error("reset pulse too short");
   a_reset_single: assert property (
      module_reset |=> !module_reset)
      else $error("reset pulse longer than one cycle");

   // Valid off-pulse seen while running
   sequence s_off_pulse;
      state == MPWS_RUN && key_rel && in_win(key_w, OFF_MIN, OFF_MAX);
   endsequence

   a_key_power_off: assert property (
      s_off_pulse |=> state == MPWS_SHUTDOWN ##1 !powered)
      else $error("power-off pulse ignored");
   a_cmd_power_off: assert property (
      state == MPWS_RUN && !key_rel && power_down_command
      |=> state == MPWS_SHUTDOWN)
      else $error("power-down command ignored");
endmodule

/* verification/mpws_host_model.sv */
// Host controller model driving the power, reset and wake lines
`timescale 1ns/100ps
module mpws_host_model
#(
   parameter int SETTLE = 100      // Supply settle time in cycles
)
(
   input  wire logic ref_clk,      // System clock
   output logic      power_key_n,  // Power key, active low
   output logic      reset_n,      // Module reset line, active low
   output wire       wake_trigger  // Wake line, pulled low
);
   logic wake_oe;                  // Wake line driven by host
   logic wake_val;                 // Level driven when enabled
   logic settled;                  // Supply has settled
   // ----------------------------------------
   // Wake line: pull-down unless driven
   // ----------------------------------------
   pulldown (wake_trigger);
   assign wake_trigger = wake_oe ? wake_val : 1'bz;
   // Idle levels: keys released, wake left floating
   initial
   begin
      power_key_n = 1'b1;
      reset_n     = 1'b1;
      wake_oe     = 1'b0;
      wake_val    = 1'b0;
      settled     = 1'b0;
      repeat (SETTLE) @(posedge ref_clk);
      settled     = 1'b1;
   end
   // Hold the power key low for n cycles, only once settled
   task automatic key_pulse(input int n);
      repeat (SETTLE) if (settled !== 1'b1) @(posedge ref_clk);
      @(posedge ref_clk);
      #2 power_key_n = 1'b0;
      repeat (n) @(posedge ref_clk);
      #2 power_key_n = 1'b1;
   endtask
   // Hold the reset line low for n cycles
   task automatic reset_pulse(input int n);
      @(posedge ref_clk);
      #2 reset_n = 1'b0;
      repeat (n) @(posedge ref_clk);
      #2 reset_n = 1'b1;
   endtask
   // Drive or release the wake line
   task automatic set_wake(input logic oe, input logic v);
      @(posedge ref_clk);
      #2 wake_oe = oe;
      wake_val = v;
   endtask
endmodule

/* verification/testbench.sv */
// Self-checking testbench of the power and wake sequencer
`timescale 1ns/100ps
module testbench;
   logic ref_clk;                  // 25 MHz clock
   logic reset;                    // Async reset, active high
   logic cmd_off;                  // Power-down command pulse
   logic ps_en;                    // Deep sleep enable level
   logic tmr;                      // Timer expiry pulse
   logic powered;                  // Module running
   logic uart_enable;              // Main UART accessible
   logic deep;                     // In deep sleep
   logic mod_rst;                  // Internal reset pulse
   logic key_n;                    // Power key line
   logic rst_n;                    // Reset line
   wire  wake;                     // Wake line
   int   error_cnt;                // Mismatches seen
   int   n_tests;                  // Comparisons made
   localparam int MS = 4;          // Clock cycles per ms, shortened
   // ----------------------------------------
   // Clock, partner and design
   // ----------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   mpws_host_model #(.SETTLE(100 * MS)) host_inst (.ref_clk(ref_clk),
      .power_key_n(key_n), .reset_n(rst_n), .wake_trigger(wake));
   mpws_sequencer #(.CYC_PER_MS(MS)) mpws_sequencer_inst (
      .ref_clk(ref_clk), .reset(reset),
      .power_key_n(key_n), .reset_n(rst_n), .wake_trigger(wake),
      .power_down_command(cmd_off), .power_saving_enable_command(ps_en),
      .periodic_update_timer(tmr), .powered(powered),
      .uart_enable(uart_enable), .registered_deep_sleep(deep),
      .module_reset(mod_rst));
   // Compare one value with its expectation
   task automatic check(input logic seen, input logic exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t ns: saw %b, expected %b", $time, seen, exp);
      end
   endtask
   // Let n clock edges pass, then settle past the last one
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #10;
   endtask
   // One-cycle power-down command pulse
   task automatic pulse_cmd();
      @(posedge ref_clk);
      #2 cmd_off = 1'b1;
      @(posedge ref_clk);
      #2 cmd_off = 1'b0;
   endtask
   // Outputs must stay at their off values for n cycles
   task automatic watch_off(input int n);
      repeat (n)
      begin
         @(posedge ref_clk);
         #10;
         check(powered, 1'b0);
         check(uart_enable, 1'b0);
         check(deep, 1'b0);
         check(mod_rst, 1'b0);
      end
   endtask
   // Key pulse one cycle below the on window is refused
   task automatic sc_short_key();
      host_inst.set_wake(1'b1, 1'b1);
      host_inst.key_pulse(500 * MS - 1);
      watch_off(40);
   endtask
   // Reset pulse below the minimum gives no internal reset
   task automatic sc_short_reset();
      host_inst.reset_pulse(100 * MS - 1);
      watch_off(40);
   endtask
   // Off-state events with the wake line floating
   task automatic sc_off_events();
      host_inst.set_wake(1'b0, 1'b0);
      #10 check(wake, 1'b0);
      #2 ps_en = 1'b1;
      @(posedge ref_clk);
      #2 cmd_off = 1'b1;
      @(posedge ref_clk);
      #2 cmd_off = 1'b0;
      tmr = 1'b1;
      @(posedge ref_clk);
      #2 tmr = 1'b0;
      watch_off(40);
      ps_en = 1'b0;
   endtask
   // Second reset in the middle of a key press
   task automatic sc_mid_reset();
      fork
         host_inst.key_pulse(600);
         begin
            repeat (300) @(posedge ref_clk);
            #2 reset = 1'b1;
            repeat (5) @(posedge ref_clk);
            #2 reset = 1'b0;
         end
      join
      watch_off(40);
   endtask
   // Power on mid-window with the wake line high or left floating
   task automatic power_on(input logic v);
      host_inst.set_wake(v, v);
      host_inst.key_pulse(750 * MS);
      step(2);
      check(powered, 1'b0);
      step(1);
      check(powered, 1'b1);
      check(uart_enable, v);
      check(deep, 1'b0);
   endtask
   // Deep sleep entry, host wake, re-entry and timer wake
   task automatic sc_psave();
      power_on(1'b1);
      @(posedge ref_clk);
      #2 ps_en = 1'b1;
      host_inst.set_wake(1'b1, 1'b0);
      step(1);
      check(uart_enable, 1'b0);
      step(1);
      check(deep, 1'b1);
      check(powered, 1'b0);
      host_inst.set_wake(1'b1, 1'b1);
      step(2);
      check(deep, 1'b0);
      check(powered, 1'b1);
      step(1);
      check(uart_enable, 1'b1);
      host_inst.set_wake(1'b1, 1'b0);
      step(2);
      check(deep, 1'b1);
      @(posedge ref_clk);
      #2 ps_en = 1'b0;
      @(posedge ref_clk);
      #2 tmr = 1'b1;
      @(posedge ref_clk);
      #2 tmr = 1'b0;
      step(1);
      check(powered, 1'b1);
      check(uart_enable, 1'b0);
      host_inst.set_wake(1'b1, 1'b1);
      step(2);
      check(uart_enable, 1'b1);
   endtask
   // Key power-off with wake pulled low, then supply cycled
   task automatic sc_key_off();
      host_inst.key_pulse(1075 * MS);
      host_inst.set_wake(1'b1, 1'b0);
      step(2);
      check(powered, 1'b0);
      check(uart_enable, 1'b0);
      step(200 * MS);
      check(powered, 1'b0);
      @(posedge ref_clk);
      #2 reset = 1'b1;
      repeat (5) @(posedge ref_clk);
      #2 reset = 1'b0;
      watch_off(2);
   endtask
   // Command off: window missed, then completed, key left high
   task automatic sc_cmd_off();
      power_on(1'b1);
      pulse_cmd();
      step(200 * MS + 1);
      check(powered, 1'b0);
      step(1);
      check(powered, 1'b1);
      pulse_cmd();
      host_inst.set_wake(1'b1, 1'b0);
      step(2);
      check(powered, 1'b0);
      watch_off(200 * MS + 8);
   endtask
   // Power on with wake floating keeps the UART closed
   task automatic sc_wake_low_on();
      power_on(1'b0);
      host_inst.key_pulse(1075 * MS);
      step(3);
      check(powered, 1'b0);
      check(uart_enable, 1'b0);
   endtask
   // Reset pulse of exactly the minimum gives one internal pulse
   task automatic sc_reset_ok();
      host_inst.reset_pulse(100 * MS);
      step(1);
      check(mod_rst, 1'b0);
      step(1);
      check(mod_rst, 1'b1);
      step(1);
      check(mod_rst, 1'b0);
   endtask
   // Verdict and end of run
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      error_cnt = 0;
      n_tests   = 0;
      reset     = 1'b1;
      cmd_off   = 1'b0;
      ps_en     = 1'b0;
      tmr       = 1'b0;
      repeat (5) @(posedge ref_clk);
      #2 reset = 1'b0;
      watch_off(2);
      sc_short_key();
      sc_short_reset();
      sc_off_events();
      sc_mid_reset();
      sc_psave();
      sc_key_off();
      sc_cmd_off();
      sc_wake_low_on();
      sc_reset_ok();
      end_of_test();
   end
endmodule
